// >>> bench/accel_event_flag_regs_test.sv
/*
 * self-checking bench of the event flag registers against a bit model.
 * assumes the host model drives the bus and the bench drives events.
 */
module accel_event_flag_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr;
    logic reg_wr, reg_rd, xfer_active, reg_hit, soft_rst, int_out;
    logic [7:0] reg_wdata, reg_rdata, src0, wd;
    logic [3:0] shake_enable;
    logic sample_ready_flag;
    accel_event_pkg::event_pulse_t events = '0;
    accel_event_pkg::orient_status_t orient = '0;
    integer mismatches = 0, tests_run = 0, cycles = 0, seed = 32'h64c8, i;

    initial forever #5 core_clk = ~core_clk;

    host_bus_model host_bus_model_inst (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .xfer_active(xfer_active));

    accel_event_flag_regs accel_event_flag_regs_inst (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .xfer_active(xfer_active),
        .events(events), .orient(orient), .shake_enable(shake_enable),
        .soft_rst(soft_rst), .int_out(int_out));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic test_done();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    // one-cycle event pulse with a new orientation level
    task automatic pulse(input logic [6:0] e, input logic [3:0] o);
        @(posedge core_clk);
        events <= e;
        orient <= o;
        @(posedge core_clk);
        events <= '0;
        src0 = src0 | {e[6], e[5], 2'b00, e[4:1]};
        sample_ready_flag = sample_ready_flag | e[0];
    endtask : pulse

    task automatic read_chk(input logic [3:0] a, input logic [7:0] exp);
        host_bus_model_inst.access(1'b0, a, 8'h00, 1'b0);
        #1;
        check("reg_rdata", exp, reg_rdata);
    endtask : read_chk

    // int_out lags flags by one edge, so two edges settle both
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
        check("int_out", {7'h00, |src0}, {7'h00, int_out});
        check("shake_enable", {4'h0, ~src0[3:0]}, {4'h0, shake_enable});
    endtask : settle

    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            mismatches++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        src0 = 8'h00;
        sample_ready_flag = 1'b0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        read_chk(4'h0, 8'h00);
        for (i = 0; i < 24; i++) begin
            pulse($random(seed), $random(seed));
            settle();
            read_chk(4'h0, src0);
            read_chk(4'h1, {orient, 3'b000, sample_ready_flag});
            wd = $random(seed);
            if (i[0]) begin
                wd[4] = 1'b0;
                sample_ready_flag = sample_ready_flag & ~wd[0];
            end else begin
                src0 = src0 & ~(wd & 8'hCF);
            end
            host_bus_model_inst.access(1'b1, {3'b000, i[0]}, wd, 1'b0);
            settle();
            read_chk({3'b000, i[0]}, i[0] ? {orient, 3'b000, sample_ready_flag} : src0);
        end
        // unmapped places: writes ignored, reads give zero
        pulse(7'h7F, 4'hA);
        host_bus_model_inst.access(1'b1, 4'h2, 8'hFF, 1'b0);
        read_chk(4'h0, src0);
        read_chk(4'hE, 8'h00);
        check("reg_hit", 8'h01, {7'h00, reg_hit});
        // soft reset holds while the transfer stays open
        host_bus_model_inst.access(1'b1, 4'h1, 8'h10, 1'b1);
        repeat (3) @(posedge core_clk);
        #1;
        check("soft_rst", 8'h01, {7'h00, soft_rst});
        src0 = 8'h00;
        sample_ready_flag = 1'b0;
        host_bus_model_inst.end_xfer();
        repeat (2) @(posedge core_clk);
        #1;
        check("soft_rst", 8'h00, {7'h00, soft_rst});
        settle();
        read_chk(4'h1, {orient, 3'b000, sample_ready_flag});
        test_done();
    end
endmodule : accel_event_flag_regs_test

// >>> bench/host_bus_model.sv
/*
 * host side model: drives the byte strobes of the register bus.
 * assumes the testbench calls access and end_xfer between clock edges.
 */
module host_bus_model (
    // clock
    input wire logic core_clk,
    // register bus
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    output logic xfer_active
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        xfer_active = 1'b0;
    end

    // one byte; held lines flip after release so stale values never match
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                          input logic keep);
        @(posedge core_clk);
        xfer_active <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge core_clk);
        xfer_active <= keep;
    endtask : access

    task automatic end_xfer();
        @(posedge core_clk);
        xfer_active <= 1'b0;
    endtask : end_xfer
endmodule : host_bus_model

// >>> hw/accel_event_defines.svh
/*
 * offsets, field positions and reset values of the event flag registers.
 * assumes inclusion by bare name from any design file.
 */
`ifndef ACCEL_EVENT_DEFINES_SVH
`define ACCEL_EVENT_DEFINES_SVH

`define REG_COUNT 16
`define ADDR_W 4
`define OFS_EVENT_0 4'h0
`define OFS_EVENT_1 4'h1
`define BIT_SHAKE_X_PLUS 0
`define BIT_SHAKE_X_MINUS 1
`define BIT_SHAKE_Y_PLUS 2
`define BIT_SHAKE_Y_MINUS 3
`define BIT_XY_CHANGE 6
`define BIT_Z_CHANGE 7
`define BIT_SAMPLE_READY 0
`define BIT_XY_CODE_LO 4
`define BIT_Z_ORIENT 6
`define BIT_TILT 7
`define BIT_SOFT_RESET 4
`define RST_FLAGS 8'h00
`define RST_STATUS 8'h00

`endif

// >>> hw/accel_event_flag_regs.sv
/*
 * event source and clear registers of the accelerometer register space.
 * assumes a bus engine on core_clk giving reg_addr, one-cycle write and
 * read strobes, and xfer_active while a serial transfer is in progress.
 */
`include "accel_event_defines.svh"

module accel_event_flag_regs #(
    parameter int REG_COUNT = `REG_COUNT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register access from the serial bus engine
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic xfer_active,
    // sensing logic
    input wire accel_event_pkg::event_pulse_t events,
    input wire accel_event_pkg::orient_status_t orient,
    output logic [3:0] shake_enable,
    output logic soft_rst,
    // pin
    output logic int_out
);

    ////////////////////////////////////////////////////////////////////////

    // shake flags take bits 0..3; sample ready is index 4; xy 5; z 6
    localparam int FLAG_N = 7;

    logic wr_ev0;
    logic wr_ev1;
    logic [FLAG_N-1:0] set_vec;
    logic [FLAG_N-1:0] clr_vec;
    logic [FLAG_N-1:0] flag_vec;
    logic [3:0] shake_raw;
    logic [7:0] src0;
    logic [7:0] src1;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;
    logic soft_cmd;

    // writes reach the clear side of shared addresses, plus the soft reset command at bit 4 of event 1
    assign wr_ev0 = reg_wr && (reg_addr == `OFS_EVENT_0);
    assign wr_ev1 = reg_wr && (reg_addr == `OFS_EVENT_1);
    assign soft_cmd = wr_ev1 && reg_wdata[`BIT_SOFT_RESET];

    ////////////////////////////////////////////////////////////////////////

    assign shake_raw = {events.shake_y_minus, events.shake_y_plus,
                        events.shake_x_minus, events.shake_x_plus};

    // a set shake flag masks its own detector until cleared
    assign shake_enable = ~flag_vec[3:0];

    assign set_vec[3:0] = shake_raw & shake_enable;
    assign set_vec[4] = events.sample_ready;
    assign set_vec[5] = events.xy_change;
    assign set_vec[6] = events.z_change;

    // clear strobes are single-cycle, so the clear bit is never stored
    assign clr_vec[0] = wr_ev0 && reg_wdata[`BIT_SHAKE_X_PLUS];
    assign clr_vec[1] = wr_ev0 && reg_wdata[`BIT_SHAKE_X_MINUS];
    assign clr_vec[2] = wr_ev0 && reg_wdata[`BIT_SHAKE_Y_PLUS];
    assign clr_vec[3] = wr_ev0 && reg_wdata[`BIT_SHAKE_Y_MINUS];
    assign clr_vec[4] = wr_ev1 && reg_wdata[`BIT_SAMPLE_READY];
    assign clr_vec[5] = wr_ev0 && reg_wdata[`BIT_XY_CHANGE];
    assign clr_vec[6] = wr_ev0 && reg_wdata[`BIT_Z_CHANGE];

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
            accel_sticky_flag u_flag (
                .core_clk(core_clk),
                .rst(rst),
                .soft_rst(soft_rst),
                .set_pulse(set_vec[gi]),
                .clear_pulse(clr_vec[gi]),
                .flag(flag_vec[gi])
            );
        end
    endgenerate

    accel_soft_reset u_soft_reset (
        .core_clk(core_clk),
        .rst(rst),
        .cmd(soft_cmd),
        .xfer_active(xfer_active),
        .soft_rst(soft_rst)
    );

    ////////////////////////////////////////////////////////////////////////

    assign src0 = {flag_vec[6], flag_vec[5], 2'b00, flag_vec[3:0]};
    assign src1 = {orient.tilt, orient.z_orient, orient.xy_code, 3'b000, flag_vec[4]};

    // other addresses belong to blocks outside; read zero here
    assign reg_hit = (reg_addr == `OFS_EVENT_0) || (reg_addr == `OFS_EVENT_1);

    assign nxt_rdata = (reg_addr == `OFS_EVENT_0) ? src0 :
                       (reg_addr == `OFS_EVENT_1) ? src1 : `RST_STATUS;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= `RST_STATUS;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // interrupt pin follows the latched causes, not the status bits
    logic int_ff;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_ff <= 1'b0;
        end else begin
            int_ff <= |{flag_vec[6:5], flag_vec[3:0]};
        end
    end
    assign int_out = int_ff;

    ////////////////////////////////////////////////////////////////////////

    a_shake_sets: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (events.shake_x_plus && shake_enable[0] && !soft_cmd) |=> flag_vec[0])
        else $error("shake flag not set");
    a_flag_sticks: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (flag_vec[5] && !clr_vec[5]) |=> flag_vec[5])
        else $error("flag lost without clear");
    a_clear_works: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (clr_vec[6] && !set_vec[6] && !soft_cmd) |=> !flag_vec[6])
        else $error("clear ignored");
    a_shake_blocks: assert property (@(posedge core_clk) disable iff (rst)
        flag_vec[2] |-> !shake_enable[2])
        else $error("shake not suppressed");
    a_ready_sets: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (events.sample_ready && !soft_cmd) |=> flag_vec[4])
        else $error("sample ready not set");
    a_read_src0: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == `OFS_EVENT_0) |=> reg_rdata == $past(src0))
        else $error("wrong source 0 read");
    a_read_src1_zero: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == `OFS_EVENT_1) |=> reg_rdata[3:1] == 3'h0)
        else $error("reserved bits not zero");
    a_int_follows: assert property (@(posedge core_clk) disable iff (rst)
        (flag_vec[0] ##1 flag_vec[0]) |-> int_out)
        else $error("interrupt not raised");
    a_zero_write: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (wr_ev0 && reg_wdata == 8'h00) |=> flag_vec[3:0] == ($past(flag_vec[3:0]) | $past(set_vec[3:0])))
        else $error("zero write changed flags");
    a_ready_clears: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (clr_vec[4] && !set_vec[4] && !soft_cmd) |=> !flag_vec[4])
        else $error("sample ready clear ignored");
    a_set_wins: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (set_vec[6] && clr_vec[6] && !soft_cmd) |=> flag_vec[6])
        else $error("coincident event lost");
    a_soft_clears: assert property (@(posedge core_clk) disable iff (rst)
        soft_rst |=> (flag_vec == '0))
        else $error("soft reset left a flag set");
    a_int_drops: assert property (@(posedge core_clk) disable iff (rst)
        (flag_vec[6:5] == 2'b00 && flag_vec[3:0] == 4'h0) |=> !int_out)
        else $error("interrupt stuck high");

endmodule : accel_event_flag_regs

// >>> hw/accel_event_pkg.sv
/*
 * types for the event flag block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package accel_event_pkg;

    // events raised by the sensing logic, one-cycle pulses
    typedef struct packed {
        logic z_change;
        logic xy_change;
        logic shake_y_minus;
        logic shake_y_plus;
        logic shake_x_minus;
        logic shake_x_plus;
        logic sample_ready;
    } event_pulse_t;

    // live orientation status
    typedef struct packed {
        logic tilt;
        logic z_orient;
        logic [1:0] xy_code;
    } orient_status_t;

    typedef enum logic [1:0] {
        SR_IDLE = 2'b00,
        SR_HOLD = 2'b01
    } soft_reset_state_t;

endpackage : accel_event_pkg

// >>> hw/accel_soft_reset.sv
/*
 * soft reset hold: asserted from the command until the bus transfer ends.
 * assumes xfer_active from the bus engine on core_clk.
 */
`include "accel_event_defines.svh"

module accel_soft_reset (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic cmd,
    input wire logic xfer_active,
    // result
    output logic soft_rst
);

    accel_event_pkg::soft_reset_state_t state_ff;
    accel_event_pkg::soft_reset_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            accel_event_pkg::SR_IDLE: begin
                if (cmd) begin
                    nxt_state = accel_event_pkg::SR_HOLD;
                end
            end
            accel_event_pkg::SR_HOLD: begin
                // held while the transfer lasts
                if (!xfer_active && !cmd) begin
                    nxt_state = accel_event_pkg::SR_IDLE;
                end
            end
            default: nxt_state = accel_event_pkg::SR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= accel_event_pkg::SR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign soft_rst = (state_ff == accel_event_pkg::SR_HOLD);

    a_reset_holds: assert property (@(posedge core_clk) disable iff (rst)
        cmd |=> soft_rst) else $error("soft reset not raised");
    a_reset_spans: assert property (@(posedge core_clk) disable iff (rst)
        (soft_rst && xfer_active) |=> soft_rst)
        else $error("soft reset dropped mid transfer");

endmodule : accel_soft_reset

// >>> hw/accel_sticky_flag.sv
/*
 * one sticky event flag; set wins over clear.
 * assumes event and clear pulses on core_clk.
 */
`include "accel_event_defines.svh"

module accel_sticky_flag (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic soft_rst,
    // control
    input wire logic set_pulse,
    input wire logic clear_pulse,
    // state
    output logic flag
);

    logic flag_ff;
    logic nxt_flag;

    // set beats clear so a coincident event survives
    assign nxt_flag = set_pulse | (flag_ff & ~clear_pulse);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (soft_rst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag = flag_ff;

endmodule : accel_sticky_flag
